// *** hw/trbsr_consts.vh ***
`ifndef TRBSR_CONSTS_VH
`define TRBSR_CONSTS_VH
// ==========================================
// function word fields
`define TRBSR_FC_HI 17
`define TRBSR_FC_LO 15
`define TRBSR_PAR_BIT 14
`define TRBSR_DEN_HI 13
`define TRBSR_DEN_LO 12
`define TRBSR_GAIN_BIT 9
`define TRBSR_UNIT_HI 3
`define TRBSR_UNIT_LO 0
// ==========================================
// main function codes
`define TRBSR_MFC_READ_BACK 3'h1
`define TRBSR_MFC_REWIND_IL 3'h2
`define TRBSR_MFC_SKIP_WRITE 3'h7
// ==========================================
// parity and density encodings
`define TRBSR_PAR_ODD 1'h0
`define TRBSR_PAR_EVEN 1'h1
`define TRBSR_DEN_MANUAL 2'h0
`define TRBSR_DEN_200 2'h1
`define TRBSR_DEN_556 2'h2
`define TRBSR_DEN_800 2'h3
// ==========================================
// status word bits
`define TRBSR_ST_AFC 17
`define TRBSR_ST_INTERLOCK 14
`define TRBSR_ST_BUSY 13
`define TRBSR_ST_INVALID 9
`define TRBSR_ST_ONE 4
// ==========================================
// word packing and timing
`define TRBSR_FRAMES_PER_WORD 3'h5
`define TRBSR_ERASE_TENTHS_IN 30
`define TRBSR_ERASE_US_PER_TENTH 10
`define TRBSR_CLK_MHZ 25
`endif

// *** hw/trbsr_ctrl.v ***
// Notes on behaviour
// - reverse frames pack low bits upward
// - late acceptance never stalls word assembly
// - short final word zero filled high
// - code 111 selects skip then write
// - parity bit zero odd one even
// - density 00 manual 01/10/11 speeds
// - skip write erases then writes normally
// - skip write follows normal write rules
// - moving tape passes gap quickly
// - code 010 rewind with interlock, unit
// - rewind starts, interlock set, status soon
// - interlocked unit reports interlock status
// - code 001 selects reverse read
// - read ends on gap after frame
// - one status per function word
`timescale 1ns/1ns
`include "trbsr_consts.vh"
// ==========================================
// reverse read, skip then write and interlocked rewind
// one function at a time, every function ends in one status word
// tape side pins are asynchronous, all but still_moving pass two flip-flops first
module trbsr_ctrl #(
    // number of addressable tape units
    parameter UNITS = 16,
    // erase span of the skip in clock cycles, about three inches of travel
    parameter ERASE_CYCLES = `TRBSR_ERASE_TENTHS_IN * `TRBSR_ERASE_US_PER_TENTH * `TRBSR_CLK_MHZ
) (
    // clock and reset
    input wire ref_clk,
    input wire srst,
    // function word from channel
    input wire func_valid,
    input wire [29:0] func_word,
    // data word to channel
    output reg data_valid,
    output reg [29:0] data_word,
    input wire data_ack,
    // status word to channel
    output reg status_valid,
    output reg [29:0] status_word,
    input wire status_ack,
    // tape unit side
    input wire frame_strobe,
    input wire [5:0] frame_data,
    input wire gap_detect,
    input wire at_speed,
    input wire still_moving,
    input wire rewind_done_pin,
    input wire interlock_clear_pin,
    output reg [3:0] sel_unit,
    output reg motor_fwd,
    output reg motor_rev,
    output reg rewind_cmd,
    output reg erase_on,
    output reg write_go,
    output reg parity_even,
    output reg [1:0] density,
    output reg low_gain,
    input wire write_done
);
// ==========================================
// states
// idle waits for a function word
// read assembles reverse frames until the gap
// spinup waits for operating speed before the erase
// erase runs the extra gap, write hands over to the write path
// status offers the one status word and waits for its acknowledge
localparam ST_IDLE = 3'h0;
localparam ST_READ = 3'h1;
localparam ST_SPINUP = 3'h2;
localparam ST_ERASE = 3'h3;
localparam ST_WRITE = 3'h4;
localparam ST_STATUS = 3'h5;

reg [2:0] state;
reg [29:0] asm_word;
reg [2:0] frame_idx;
reg got_frame;
reg [31:0] erase_cnt;
reg [UNITS-1:0] rw_busy;
reg [UNITS-1:0] il_flag;
reg afc;
reg interlocked_hit;
reg [1:0] done_s1;
reg [1:0] clr_s1;
reg [2:0] fs_s;
reg [1:0] gap_s;
reg [1:0] spd_s;
reg [1:0] wd_s;
reg [5:0] fd_s1;
reg [5:0] fd_s2;
reg [29:0] next_status_word;

// ==========================================
// pin synchronisers
// every tape side pin is asynchronous to ref_clk
// two stages before any logic looks at it, except still_moving which is used directly
// frame data passes the same depth as the strobe
// so the data seen at the edge is the data around the strobe
always @(posedge ref_clk) begin
    done_s1 <= {done_s1[0], rewind_done_pin};
    clr_s1 <= {clr_s1[0], interlock_clear_pin};
    fs_s <= {fs_s[1:0], frame_strobe};
    gap_s <= {gap_s[0], gap_detect};
    spd_s <= {spd_s[0], at_speed};
    wd_s <= {wd_s[0], write_done};
    fd_s1 <= frame_data;
    fd_s2 <= fd_s1;
end

// frame event on the rising strobe, one cycle wide
// third stage only remembers the previous level
wire frame_ev = fs_s[1] & ~fs_s[2];
// fields of the function word
wire [2:0] fc = func_word[`TRBSR_FC_HI:`TRBSR_FC_LO];
wire [3:0] fu = func_word[`TRBSR_UNIT_HI:`TRBSR_UNIT_LO];
wire unit_locked = rw_busy[fu] | il_flag[fu];

// ==========================================
// per unit rewind and interlock tracking
// a new rewind start wins over a clear in the same cycle
// rewind done and interlock clear act on the selected unit
// interlock clears only once that unit has stopped rewinding
genvar g;
generate
    for (g = 0; g < UNITS; g = g + 1) begin : g_unit
        always @(posedge ref_clk) begin
            if (srst) begin
                rw_busy[g] <= 1'b0;
                il_flag[g] <= 1'b0;
            end else if (state == ST_IDLE && func_valid && fc == `TRBSR_MFC_REWIND_IL
                         && fu == g && !unit_locked) begin
                rw_busy[g] <= 1'b1;
                il_flag[g] <= 1'b1;
            end else begin
                if (done_s1[1] && sel_unit == g)
                    rw_busy[g] <= 1'b0;
                if (clr_s1[1] && !rw_busy[g] && sel_unit == g)
                    il_flag[g] <= 1'b0;
            end
        end
    end
endgenerate

// ==========================================
// status word image
// bit 4 always set, interlock, short word flag and frame count
always @* begin
    next_status_word = 30'h0;
    next_status_word[`TRBSR_ST_ONE] = 1'b1;
    next_status_word[`TRBSR_ST_INTERLOCK] = interlocked_hit;
    next_status_word[`TRBSR_ST_AFC] = afc;
    next_status_word[3:0] = {1'b0, frame_idx};
end

// ==========================================
// main sequencer
// all outputs are registered here or in the tracking above
// data words never wait for the channel: a late acknowledge
// simply lets the next word replace the one still offered
always @(posedge ref_clk) begin
    if (srst) begin
        state <= ST_IDLE;
        asm_word <= 30'h0;
        frame_idx <= 3'h0;
        got_frame <= 1'b0;
        erase_cnt <= 32'h0;
        afc <= 1'b0;
        interlocked_hit <= 1'b0;
        data_valid <= 1'b0;
        data_word <= 30'h0;
        status_valid <= 1'b0;
        status_word <= 30'h0;
        sel_unit <= 4'h0;
        motor_fwd <= 1'b0;
        motor_rev <= 1'b0;
        rewind_cmd <= 1'b0;
        erase_on <= 1'b0;
        write_go <= 1'b0;
        parity_even <= 1'b0;
        density <= 2'h0;
        low_gain <= 1'b0;
    end else begin
        rewind_cmd <= 1'b0;
        if (data_ack)
            data_valid <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (func_valid) begin
                    sel_unit <= fu;
                    parity_even <= func_word[`TRBSR_PAR_BIT];
                    density <= func_word[`TRBSR_DEN_HI:`TRBSR_DEN_LO];
                    low_gain <= func_word[`TRBSR_GAIN_BIT];
                    interlocked_hit <= 1'b0;
                    afc <= 1'b0;
                    // no frame count left over from an earlier read
                    frame_idx <= 3'h0;
                    if (unit_locked) begin
                        interlocked_hit <= 1'b1;
                        state <= ST_STATUS;
                    end else if (fc == `TRBSR_MFC_READ_BACK) begin
                        // never drive both directions at once
                        motor_fwd <= 1'b0;
                        motor_rev <= 1'b1;
                        asm_word <= 30'h0;
                        frame_idx <= 3'h0;
                        got_frame <= 1'b0;
                        state <= ST_READ;
                    end else if (fc == `TRBSR_MFC_SKIP_WRITE) begin
                        motor_fwd <= 1'b1;
                        erase_cnt <= 32'h0;
                        // tape still moving with motor_fwd already on skips the spin-up wait
                        state <= (still_moving && motor_fwd) ? ST_ERASE : ST_SPINUP;
                    end else if (fc == `TRBSR_MFC_REWIND_IL) begin
                        // rewind takes the tape away from forward motion
                        motor_fwd <= 1'b0;
                        rewind_cmd <= 1'b1;
                        state <= ST_STATUS;
                    end else begin
                        motor_fwd <= 1'b0;
                        state <= ST_STATUS;
                    end
                end
            end
            // reverse frames fill the word from the low end
            // the fifth frame completes the word and offers it
            // a gap after a frame ends the read, a short word goes out zero filled
            ST_READ: begin
                if (frame_ev) begin
                    got_frame <= 1'b1;
                    if (frame_idx == `TRBSR_FRAMES_PER_WORD - 3'h1) begin
                        // offered regardless of pending ack
                        data_word <= {fd_s2, asm_word[23:0]};
                        data_valid <= 1'b1;
                        asm_word <= 30'h0;
                        frame_idx <= 3'h0;
                    end else begin
                        asm_word <= asm_word | ({24'h0, fd_s2} << (6 * frame_idx));
                        frame_idx <= frame_idx + 3'h1;
                    end
                end else if (gap_s[1] && got_frame) begin
                    if (frame_idx != 3'h0) begin
                        data_word <= asm_word;
                        data_valid <= 1'b1;
                        afc <= 1'b1;
                    end
                    motor_rev <= 1'b0;
                    state <= ST_STATUS;
                end
            end
            ST_SPINUP: begin
                if (spd_s[1])
                    state <= ST_ERASE;
            end
            // erase stands for exactly ERASE_CYCLES cycles
            // the write path starts in the cycle the erase ends
            ST_ERASE: begin
                erase_on <= 1'b1;
                erase_cnt <= erase_cnt + 32'h1;
                if (erase_cnt == ERASE_CYCLES) begin
                    erase_on <= 1'b0;
                    write_go <= 1'b1;
                    state <= ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (wd_s[1]) begin
                    write_go <= 1'b0;
                    state <= ST_STATUS;
                end
            end
            ST_STATUS: begin
                if (!status_valid) begin
                    status_word <= next_status_word;
                    status_valid <= 1'b1;
                end else if (status_ack) begin
                    status_valid <= 1'b0;
                    state <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule

// *** verif/trbsr_chk_assertions.sv ***
`timescale 1ns/1ns
// ==========
// channel and tape side checks
module trbsr_chk (
    // clock and reset
    input wire ref_clk,
    input wire srst,
    // channel side
    input wire [29:0] func_word,
    input wire data_valid,
    input wire data_ack,
    input wire status_valid,
    input wire [29:0] status_word,
    input wire status_ack,
    // tape side
    input wire [3:0] sel_unit,
    input wire motor_fwd,
    input wire motor_rev,
    input wire rewind_cmd,
    input wire erase_on,
    input wire write_go,
    input wire parity_even,
    input wire [1:0] density,
    input wire low_gain
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_status_one_bit: assert property (status_valid |-> status_word[4])
        else $error("status word bit 4 low");
    a_status_stands: assert property (status_valid && !status_ack |=> status_valid)
        else $error("status dropped before ack");
    a_data_stands: assert property (data_valid && !data_ack |=> data_valid)
        else $error("data word dropped before ack");
    a_rewind_then_status: assert property ($rose(rewind_cmd) |=> status_valid)
        else $error("no status after rewind start");
    a_rewind_one_pulse: assert property (rewind_cmd |=> !rewind_cmd)
        else $error("rewind command longer than one cycle");
    a_rewind_unit_sel: assert property (rewind_cmd |-> sel_unit == func_word[3:0])
        else $error("rewind on wrong unit");
    a_erase_mode_bits: assert property (erase_on |->
        parity_even == func_word[14] && density == func_word[13:12])
        else $error("parity or density not from function word");
    a_erase_gain_bit: assert property (erase_on |-> low_gain == func_word[9])
        else $error("gain not from function word");
    a_erase_to_write: assert property ($fell(erase_on) |-> ##[0:2] write_go)
        else $error("write did not follow erase");
    a_motor_one_way: assert property (!(motor_fwd && motor_rev))
        else $error("both tape directions driven");
endmodule
bind trbsr_ctrl trbsr_chk u_chk (.*);

// *** verif/trbsr_tape.sv ***
`timescale 1ns/1ns
// ==========
// tape unit model
module trbsr_tape #(
    parameter SPEED_DLY = 6,
    parameter WRITE_DLY = 8
) (
    // clock
    input wire ref_clk,
    // motion and write control
    input wire motor_fwd,
    input wire write_go,
    // unit state
    output reg at_speed,
    output reg write_done
);
    integer n = 0;
    integer w = 0;
    initial at_speed = 1'b0;
    initial write_done = 1'b0;
    // speed ramp and write completion delays
    always @(posedge ref_clk) begin
        n <= motor_fwd ? n + 1 : 0;
        w <= write_go ? w + 1 : 0;
        at_speed <= motor_fwd && n >= SPEED_DLY;
        write_done <= write_go && w >= WRITE_DLY;
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    // ==========
    // dut signals
    reg ref_clk = 0, srst = 1, func_valid = 0, data_ack = 0, status_ack = 0;
    reg frame_strobe = 0, gap_detect = 0, still_moving = 0;
    reg rewind_done_pin = 0, interlock_clear_pin = 0;
    reg [29:0] func_word = 30'h0;
    reg [5:0] frame_data = 6'h00;
    wire data_valid, status_valid, at_speed, write_done, motor_fwd, motor_rev, write_go;
    wire erase_on, parity_even, low_gain, rewind_cmd;
    wire [29:0] data_word, status_word;
    wire [3:0] sel_unit;
    wire [1:0] density;
    integer n_fail = 0, n_compared = 0, n_rw = 0, i, j, k, n;
    reg [29:0] st;
    reg [29:0] rows [0:3];
    always #20 ref_clk = ~ref_clk;
    trbsr_ctrl #(.ERASE_CYCLES(20)) u_dut (.*);
    trbsr_tape u_tape (.*);
    // count rewind starts
    always @(posedge ref_clk) if (rewind_cmd === 1'b1) n_rw <= n_rw + 1;
    task chk(input [29:0] seen, input [29:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one function word, wait status, acknowledge it
    task do_func(input [29:0] w);
        begin
            @(posedge ref_clk) func_word <= w;
            func_valid <= 1'b1;
            k = 0;
            @(negedge ref_clk);
            while (status_valid !== 1'b1 && k < 3000) begin
                @(negedge ref_clk);
                k = k + 1;
            end
            chk(status_valid, 30'h1);
            st = status_word;
            @(posedge ref_clk) func_valid <= 1'b0;
            @(posedge ref_clk) status_ack <= 1'b1;
            @(posedge ref_clk) status_ack <= 1'b0;
        end
    endtask
    // one frame, data stable around the strobe
    task frame(input [5:0] v);
        begin
            @(posedge ref_clk) frame_data <= v;
            repeat (3) @(posedge ref_clk);
            frame_strobe <= 1'b1;
            repeat (4) @(posedge ref_clk);
            frame_strobe <= 1'b0;
            repeat (3) @(posedge ref_clk);
            frame_data <= ~v;
        end
    endtask
    task take_word(input [29:0] exp);
        begin
            j = 0;
            @(negedge ref_clk);
            while (data_valid !== 1'b1 && j < 500) begin
                @(negedge ref_clk);
                j = j + 1;
            end
            chk(data_valid, 30'h1);
            chk(data_word, exp);
            @(posedge ref_clk) data_ack <= 1'b1;
            @(posedge ref_clk) data_ack <= 1'b0;
        end
    endtask
    // watchdog
    initial begin
        #400000;
        n_fail = n_fail + 1;
        give_verdict;
    end
    // ==========
    // main sequence
    initial begin
        rows[0] = 30'h38203;
        rows[1] = 30'h3d206;
        rows[2] = 30'h3a209;
        rows[3] = 30'h3f20c;
        repeat (5) @(posedge ref_clk);
        chk({status_valid, data_valid, motor_fwd, rewind_cmd}, 30'h0);
        srst <= 1'b0;
        // skip then write rows over parity and density codes
        for (i = 0; i < 4; i = i + 1) begin
            still_moving <= (i == 3);
            fork
                do_func(rows[i]);
                begin
                    @(posedge erase_on);
                    @(negedge ref_clk);
                    chk({parity_even, density, low_gain, sel_unit},
                        {rows[i][14:12], rows[i][9], rows[i][3:0]});
                    n = 0;
                    while (erase_on === 1'b1) begin
                        @(negedge ref_clk);
                        n = n + 1;
                    end
                    chk(n, 20);
                end
            join
            chk(st[17:4], 30'h1);
        end
        still_moving <= 1'b0;
        // reverse read of seven frames, short final word
        fork
            do_func(30'hf202);
            begin
                for (i = 1; i <= 7; i = i + 1) frame(i[5:0] + 6'h10);
                gap_detect <= 1'b1;
            end
            begin
                take_word({6'h15, 6'h14, 6'h13, 6'h12, 6'h11});
                take_word({18'h0, 6'h17, 6'h16});
            end
        join
        chk({st[17], st[3:0]}, 30'h12);
        gap_detect <= 1'b0;
        // ten frames never accepted, newest word stays offered
        fork
            do_func(30'h9202);
            begin
                for (i = 1; i <= 10; i = i + 1) frame(i[5:0]);
                gap_detect <= 1'b1;
            end
        join
        take_word({6'h0a, 6'h09, 6'h08, 6'h07, 6'h06});
        chk({st[17], st[3:0]}, 30'h0);
        gap_detect <= 1'b0;
        // skip then write after the reverse read, long gap recovery
        do_func(30'h3a202);
        chk(st[17:4], 30'h1);
        // rewind with interlock, then a locked access, then clear
        do_func(30'h10005);
        chk(n_rw, 1);
        do_func(30'h38205);
        chk({st[14], n_rw[3:0]}, 30'h11);
        rewind_done_pin <= 1'b1;
        interlock_clear_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rewind_done_pin <= 1'b0;
        interlock_clear_pin <= 1'b0;
        do_func(30'h10005);
        chk({st[14], n_rw[3:0]}, 30'h02);
        give_verdict;
    end
endmodule
